// File: include/tcdi_pkg.sv
// Package: constants for the two-channel digital input block
package tcdi_pkg;
  // ==========================================================
  // Register map
  localparam logic [3:0] REG_INPUT_STATES = 4'h0;
  localparam logic [3:0] REG_MODULE_ID = 4'h1;
  localparam int NUM_CHANNELS = 2;
  localparam int BIT_CH0 = 0;
  localparam int BIT_CH1 = 1;
  localparam logic [7:0] RESERVED_READ = 8'h00;
  // Identification value is arbitrary
  localparam logic [31:0] MODULE_ID_DEFAULT = 32'h0000_2a51;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 25000000;
  localparam int FILTER_US = 3000;
  localparam int FILTER_CYCLES = (CLK_HZ / 1000000) * FILTER_US;
  // Flash period for configuration error, half period
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_CYCLES = (CLK_HZ / 1000) * FLASH_HALF_MS;
  // ==========================================================
  // Indicator modes
  typedef enum logic [4:0] {
    IND_OK = 5'h01,
    IND_MOD_ERR = 5'h02,
    IND_BUS_LOST = 5'h04,
    IND_PWR_ERR = 5'h08,
    IND_CFG_ERR = 5'h10
  } tcdi_ind_e;
endpackage

// File: hw/tcdi_filter.sv
// Module: per-channel fixed-delay input filter
`timescale 1ns/10ps
module tcdi_filter #(
  parameter int DELAY_CYCLES = tcdi_pkg::FILTER_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // Raw and filtered level
  input wire logic i_raw,
  output logic o_state
);
  localparam int CW = $clog2(DELAY_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(DELAY_CYCLES - 1);

  initial begin
    if (DELAY_CYCLES < 1) $error("delay must be at least one cycle");
  end

  logic [CW-1:0] cnt, next_cnt;
  logic state, next_state;

  always_comb begin
    next_cnt = cnt;
    next_state = state;
    if (i_raw == state) begin
      next_cnt = '0;
    end else if (cnt == LAST) begin
      next_state = i_raw;
      next_cnt = '0;
    end else begin
      next_cnt = cnt + CW'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt <= '0;
      state <= 1'b0;
    end else if (i_ce) begin
      cnt <= next_cnt;
      state <= next_state;
    end
  end

  assign o_state = state;
endmodule // tcdi_filter

// File: hw/tcdi_top.sv
// Module: two-channel digital input with process image and indicators
// ==========================================================
// Notes on behaviour
// - Two independent channels, one bit each
// - Read-only byte at offset zero, reserved zero
// - Bus writes are ignored entirely
// - Rising edge reported after three milliseconds
// - Falling edge reported after three milliseconds
// - Green indicator follows filtered channel always
// - Run and fault indicators show five states
// - No interrupts, parameters or diagnostics
`timescale 1ns/10ps
module tcdi_top #(
  parameter int NCH = tcdi_pkg::NUM_CHANNELS,
  parameter int FILTER_CYCLES = tcdi_pkg::FILTER_CYCLES,
  parameter int FLASH_CYCLES = tcdi_pkg::FLASH_CYCLES,
  parameter logic [31:0] MODULE_ID = tcdi_pkg::MODULE_ID_DEFAULT
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // Field inputs
  input wire logic i_field_input_ch0,
  input wire logic i_field_input_ch1,
  // Register access
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [1:0] i_id_byte,
  output logic [7:0] o_rdata,
  // System status
  input wire logic i_bus_ok,
  input wire logic i_bus_pwr_ok,
  input wire logic i_module_err,
  input wire logic i_config_err,
  // Indicators
  output logic [1:0] o_channel_state_indicator,
  output logic o_run_indicator,
  output logic o_module_fault_indicator
);
  initial begin
    if (NCH != 2) $error("block serves exactly two channels");
    if (FILTER_CYCLES < 1) $error("filter delay must be at least one cycle");
    if (FLASH_CYCLES < 2) $error("flash period too short");
  end

  // ==========================================================
  // Channel filters
  logic [NCH-1:0] raw;
  logic [NCH-1:0] filt;
  assign raw = {i_field_input_ch1, i_field_input_ch0};

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      tcdi_filter #(.DELAY_CYCLES(FILTER_CYCLES)) u_filt (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_raw(raw[g]),
        .o_state(filt[g])
      );
    end
  endgenerate

  // Indicators are not gated by bus state so they work without bus supply
  assign o_channel_state_indicator = filt;

  // ==========================================================
  // Register read path; writes have no decode at all
  function automatic logic [7:0] id_byte(input logic [31:0] id, input logic [1:0] sel);
    id_byte = id[8*sel +: 8];
  endfunction

  logic [7:0] rdata, next_rdata;
  logic unused_wr;
  assign unused_wr = i_wr ^ (^i_wdata);

  always_comb begin
    next_rdata = rdata;
    if (i_rd) begin
      unique case (i_addr)
        tcdi_pkg::REG_INPUT_STATES: begin
          next_rdata = tcdi_pkg::RESERVED_READ;
          next_rdata[tcdi_pkg::BIT_CH0] = filt[0];
          next_rdata[tcdi_pkg::BIT_CH1] = filt[1];
        end
        tcdi_pkg::REG_MODULE_ID: begin
          next_rdata = id_byte(MODULE_ID, i_id_byte);
        end
        default: begin
          next_rdata = tcdi_pkg::RESERVED_READ;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata <= 8'h00;
    end else if (i_ce) begin
      rdata <= next_rdata;
    end
  end
  assign o_rdata = rdata;

  // ==========================================================
  // Module indicators
  localparam int FW = $clog2(FLASH_CYCLES + 1);
  localparam logic [FW-1:0] FLASH_LAST = FW'(FLASH_CYCLES - 1);

  tcdi_pkg::tcdi_ind_e mode, next_mode;
  logic [FW-1:0] fcnt, next_fcnt;
  logic flash, next_flash;
  logic run, next_run, fault, next_fault;

  // ==========================================================
  // Flash timer; runs on every enabled cycle regardless of mode, so the pattern phase stalls only while i_ce is low
  always_comb begin
    next_fcnt = (fcnt == FLASH_LAST) ? '0 : fcnt + FW'(1);
    next_flash = (fcnt == FLASH_LAST) ? ~flash : flash;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fcnt <= '0;
      flash <= 1'b0;
    end else if (i_ce) begin
      fcnt <= next_fcnt;
      flash <= next_flash;
    end
  end

  // ==========================================================
  // Status priority
  always_comb begin
    // Power error dominates, since the bus cannot be trusted then
    if (!i_bus_pwr_ok) next_mode = tcdi_pkg::IND_PWR_ERR;
    else if (i_config_err) next_mode = tcdi_pkg::IND_CFG_ERR;
    else if (!i_bus_ok) next_mode = tcdi_pkg::IND_BUS_LOST;
    else if (i_module_err) next_mode = tcdi_pkg::IND_MOD_ERR;
    else next_mode = tcdi_pkg::IND_OK;
  end

  // Reset shows the power error pattern until status is sampled
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode <= tcdi_pkg::IND_PWR_ERR;
    end else if (i_ce) begin
      mode <= next_mode;
    end
  end

  // ==========================================================
  // Indicator pattern per mode, one cycle behind the mode register
  always_comb begin
    unique case (mode)
      tcdi_pkg::IND_OK: begin
        next_run = 1'b1;
        next_fault = 1'b0;
      end
      tcdi_pkg::IND_MOD_ERR: begin
        next_run = 1'b1;
        next_fault = 1'b1;
      end
      tcdi_pkg::IND_BUS_LOST: begin
        next_run = 1'b0;
        next_fault = 1'b1;
      end
      tcdi_pkg::IND_PWR_ERR: begin
        next_run = 1'b0;
        next_fault = 1'b0;
      end
      tcdi_pkg::IND_CFG_ERR: begin
        next_run = flash;
        next_fault = flash;
      end
      default: begin
        next_run = 1'b0;
        next_fault = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      run <= 1'b0;
      fault <= 1'b0;
    end else if (i_ce) begin
      run <= next_run;
      fault <= next_fault;
    end
  end

  assign o_run_indicator = run;
  assign o_module_fault_indicator = fault;
endmodule // tcdi_top

// File: testbench/tcdi_properties.sv
// Checker: port properties of the input block
`timescale 1ns/10ps
module tcdi_properties #(parameter int FILTER_CYCLES = 10) (
  input wire logic i_clk, i_nrst, i_ce, i_field_input_ch0, i_rd, i_wr,
  input wire logic i_bus_ok, i_bus_pwr_ok, i_module_err, i_config_err,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] o_rdata,
  input wire logic [1:0] o_channel_state_indicator,
  input wire logic o_run_indicator, o_module_fault_indicator
);
  int hi;
  logic ok;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // Enabled cycles that raw channel 0 has stayed high
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst) hi <= 0;
    else if (i_ce) hi <= i_field_input_ch0 ? hi + 1 : 0;
  assign ok = i_bus_pwr_ok && !i_config_err;
  AST_WR_IGNORED: assert property (i_ce && i_wr && !i_rd |=> $stable(o_rdata))
    else $error("write moved read data");
  AST_RESERVED: assert property (i_ce && i_rd && i_addr == 4'h0 |=> o_rdata[7:2] == 6'h0)
    else $error("reserved bits set");
  AST_UNMAPPED: assert property (i_ce && i_rd && i_addr > 4'h1 |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_PWR: assert property ((i_ce && !i_bus_pwr_ok) [*3] |-> !o_run_indicator && !o_module_fault_indicator)
    else $error("power error pattern");
  AST_BUS_LOST: assert property ((i_ce && ok && !i_bus_ok) [*3] |-> !o_run_indicator && o_module_fault_indicator)
    else $error("bus lost pattern");
  AST_MOD_ERR: assert property ((i_ce && ok && i_bus_ok && i_module_err) [*3] |-> o_run_indicator && o_module_fault_indicator)
    else $error("module error pattern");
  AST_HEALTHY: assert property ((i_ce && ok && i_bus_ok && !i_module_err) [*3] |-> o_run_indicator && !o_module_fault_indicator)
    else $error("healthy pattern");
  AST_RISE_LATE: assert property ($rose(o_channel_state_indicator[0]) |-> hi >= FILTER_CYCLES)
    else $error("channel rose early");
  AST_RISE_DONE: assert property (hi == FILTER_CYCLES + 2 |-> o_channel_state_indicator[0])
    else $error("channel rise missing");
endmodule // tcdi_properties
bind tcdi_top tcdi_properties #(.FILTER_CYCLES(FILTER_CYCLES)) u_props (.*);

// File: testbench/tcdi_head.sv
// Model of the head station on the backplane side
`timescale 1ns/10ps
module tcdi_head (
  input wire logic i_clk,
  output logic o_rd, o_wr,
  output logic [3:0] o_addr,
  output logic [7:0] o_wdata,
  output logic [1:0] o_id_byte
);
  initial {o_rd, o_wr, o_addr, o_wdata, o_id_byte} = '0;
  // One-cycle strobe; address parked elsewhere afterwards
  task automatic acc(input logic w, input logic [3:0] a, input logic [1:0] b);
    @(negedge i_clk);
    o_rd <= !w;
    o_wr <= w;
    o_addr <= a;
    o_id_byte <= b;
    o_wdata <= 8'($urandom);
    @(negedge i_clk);
    o_rd <= 1'b0;
    o_wr <= 1'b0;
    o_addr <= ~a;
  endtask
endmodule // tcdi_head

// File: testbench/tb.sv
// Testbench for the two-channel input block
`timescale 1ns/10ps
module tb;
  logic clk = 0, nrst = 0, ce = 1, ch0 = 0, ch1 = 0;
  logic bus_ok = 1, pwr_ok = 1, mod_err = 0, cfg_err = 0, rd, wr, run, flt;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, e;
  logic [1:0] idb, ind;
  logic [7:0] q[$];
  logic [3:0] st[5] = '{4'b1100, 4'b1110, 4'b0100, 4'b1000, 4'b1101};
  logic [1:0] ex[4] = '{2'b10, 2'b11, 2'b01, 2'b00};
  logic [1:0] r0;
  int n_mismatch = 0, total_checks = 0, cyc = 0;
  always #20 clk = ~clk;
  tcdi_head head (.i_clk(clk), .o_rd(rd), .o_wr(wr), .o_addr(addr), .o_wdata(wdata),
    .o_id_byte(idb));
  tcdi_top #(.FILTER_CYCLES(10), .FLASH_CYCLES(4)) DUT (.i_clk(clk), .i_nrst(nrst),
    .i_ce(ce), .i_field_input_ch0(ch0), .i_field_input_ch1(ch1), .i_rd(rd), .i_wr(wr),
    .i_addr(addr), .i_wdata(wdata), .i_id_byte(idb), .o_rdata(rdata), .i_bus_ok(bus_ok),
    .i_bus_pwr_ok(pwr_ok), .i_module_err(mod_err), .i_config_err(cfg_err),
    .o_channel_state_indicator(ind), .o_run_indicator(run), .o_module_fault_indicator(flt));
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [1:0] b, input logic [7:0] x);
    q.push_back(x);
    head.acc(1'b0, a, b);
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Read taken at the edge just passed; data already settled
  always @(negedge clk) begin
    if (rd && ce) begin
      e = q.pop_front();
      total_checks++;
      if (rdata !== e) begin
        n_mismatch++;
        $display("wrong value at %0t: got %h expected %h", $time, rdata, e);
      end
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    void'($urandom(83));
    hold(16);
    nrst = 1;
    rd_chk(4'h0, 2'h0, 8'h00);
    for (int b = 0; b < 4; b++)
      rd_chk(4'h1, 2'(b), 8'(tcdi_pkg::MODULE_ID_DEFAULT >> 8 * b));
    for (int a = 0; a < 16; a++) begin
      head.acc(1'b1, 4'(a), 2'h0);
      if (a > 1) rd_chk(4'(a), 2'h0, 8'h00);
    end
    rd_chk(4'h0, 2'h0, 8'h00);
    ch0 = 1;
    hold(5);
    ch0 = 0;
    hold(8);
    rd_chk(4'h0, 2'h0, 8'h00);
    ch0 = 1;
    ch1 = 1;
    hold(7);
    rd_chk(4'h0, 2'h0, 8'h00);
    hold(6);
    rd_chk(4'h0, 2'h0, 8'h03);
    ch1 = 0;
    hold(6);
    rd_chk(4'h0, 2'h0, 8'h03);
    hold(6);
    rd_chk(4'h0, 2'h0, 8'h01);
    foreach (st[i]) begin
      {bus_ok, pwr_ok, mod_err, cfg_err} = st[i];
      hold(12);
      cmp(8'(ind), 8'h01);
      if (i < 4) cmp(8'({run, flt}), 8'(ex[i]));
    end
    r0 = {run, flt};
    cmp(8'(r0), 8'({2{r0[1]}}));
    hold(4);
    cmp(8'({run, flt}), 8'({2{~r0[1]}}));
    ce = 0;
    ch0 = 0;
    hold(20);
    cmp(8'(ind), 8'h01);
    ce = 1;
    hold(12);
    cmp(8'(ind), 8'h00);
    test_done();
  end
endmodule // tb
